// File: design/clkgen_pkg.sv
// How it works
// - system clock is oscillator divided by 2^code, code 000 gives /1, 111 gives /128
// - eight-bit trim resets to all ones; lower code means faster oscillator
// - shutdown bit powers down; any input falling edge wakes with power-on reset
// - software sets port hold first; ports freeze and button presses wait
// - read-only bit 5 flags power-up caused by battery insertion
// - writing one to tick-clear resets the realtime 5.12ns counter; zero does nothing
// - two-bit bias probe: none, sense, force, sense and force
// - interval counter runs from one of five slow sources, gating tank or divider
// - source mode zero alone disables; stops at once; re-enable may follow directly
// - nonzero mode idles; writing running one starts and clears finished flag
// - after start and sync delay, wait first interval rising edge, then count
// - after programmed cycles, next interval rising edge stops counting
// - on finish clear running, then after sync delay set finished
// - after stop both counters hold; tally kept through disable until retrigger
// - tally is 23 bits, read as four-byte word in extended space
// - tally read while running returns live value
// - running write during measurement discards result and retriggers
// - interval cycles = (2 + code[0]) * 2^code[5:1]
// - interval codes above 43 force a single cycle
// - modes: 000 off, 001 ext, 010 osc, 011 sysclk, 100 crystal, 110 sleep timer
// - fast select 0 tank, 1 divider; both inactive while disabled
// - finished flag is level interrupt, writable so one raises it
package clkgen_pkg;
  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [7:0]  SFR_SYSTEM_CLOCK_POWER_CONTROL    = 8'hbe;
  localparam logic [7:0]  SFR_METER_CTL = 8'h9b;
  localparam logic [7:0]  SFR_METER_SPN = 8'h9d;
  localparam logic [15:0] XR_TRIM       = 16'h4002;
  localparam logic [15:0] XR_TALLY      = 16'h4008;
  localparam logic [15:0] XR_CRYSTAL    = 16'h4016;
  // ------------------------------------------------------------
  // fields and resets
  // ------------------------------------------------------------
  localparam int SG_OFF = 7;
  localparam int SG_BAT = 5;
  localparam int SG_TCK = 4;
  localparam int SG_HLD = 3;
  localparam int MC_FIN = 7;
  localparam int MC_RUN = 6;
  localparam int MC_FSL = 5;
  localparam logic [7:0] TRIM_RST    = 8'hff;
  localparam logic [4:0] SYNC_CYC    = 5'h03;
  localparam logic [5:0] SPAN_MAX    = 6'h2b;
  localparam int         TALLY_W     = 23;
  localparam int         TICK_NS_X100 = 512;
  localparam int         CLK_NS      = 4;
  localparam int         TICK_CYC    = TICK_NS_X100 / (100 * CLK_NS);
  typedef enum logic [2:0] {
    SRC_OFF = 3'h0, SRC_EXT = 3'h1, SRC_OSC = 3'h2, SRC_SYS = 3'h3,
    SRC_XTL = 3'h4, SRC_SLP = 3'h6
  } src_e;
  typedef enum logic [4:0] {
    M_IDLE = 5'h01, M_SYNC = 5'h02, M_WAIT = 5'h04, M_CNT = 5'h08, M_FIN = 5'h10
  } meter_e;

  // interval length in slow-clock cycles
  function automatic logic [24:0] span_cycles(input logic [5:0] code);
    logic [24:0] base;
    base = code[0] ? 25'h0000003 : 25'h0000002;
    if (code > SPAN_MAX)
      span_cycles = 25'h0000001;
    else
      span_cycles = base << code[5:1];
  endfunction
endpackage

// File: design/clk_div.sv
`timescale 1ns/10ps
`default_nettype none
module clk_div
  import clkgen_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic [2:0] i_sel,
  output logic            o_tick
);
  typedef struct packed { logic [6:0] cnt; logic tick; } div_s;
  div_s s_q, s_d;
  logic [6:0] lim;
  always_comb
  begin
    s_d = s_q;
    lim = 7'(({7'h00, 1'b1} << i_sel) - 8'h01);
    s_d.tick = (s_q.cnt >= lim); // divide by 2^sel
    s_d.cnt = s_d.tick ? 7'h00 : s_q.cnt + 7'h01;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign o_tick = s_q.tick;
endmodule
`default_nettype wire

// File: design/edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module edge_sync
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_lvl,
  output logic      o_rise
);
  typedef struct packed { logic m; logic s; logic p; } es_s;
  es_s s_q, s_d;
  always_comb
  begin
    s_d = s_q;
    s_d.m = i_lvl;
    s_d.s = s_q.m;
    s_d.p = s_q.s;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  // the second and third stages feed the edge detect
  assign o_rise = s_q.s & ~s_q.p;
endmodule
`default_nettype wire

// File: design/clock_gen_freq_counter.sv
`timescale 1ns/10ps
`default_nettype none
module clock_gen_freq_counter
  import clkgen_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_sfr_we,
  input  wire logic        i_sfr_re,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic      [7:0]  o_sfr_rdata,
  input  wire logic        i_xreg_we,
  input  wire logic        i_xreg_re,
  input  wire logic [15:0] i_xreg_addr,
  input  wire logic [7:0]  i_xreg_wdata,
  output logic      [7:0]  o_xreg_rdata,
  input  wire logic        i_battery_insert,
  input  wire logic [7:0]  i_gpio,
  input  wire logic        i_ext_ref,
  input  wire logic        i_osc_clk,
  input  wire logic        i_crystal_clock,
  input  wire logic        i_sleep_tick,
  input  wire logic        i_tank_oscillator,
  input  wire logic        i_divider_clk,
  output logic             o_sysclk_tick,
  output logic      [7:0]  o_osc_trim_code,
  output logic             o_general_power_off,
  output logic             o_power_on_reset,
  output logic             o_port_hold,
  output logic      [7:0]  o_gpio_held,
  output logic             o_button_pending,
  output logic             o_realtime_tick_clear,
  output logic      [1:0]  o_crystal_bias_probe,
  output logic             o_small_load_cap,
  output logic             o_crystal_osc_on,
  output logic             o_tank_enable,
  output logic             o_divider_enable,
  output logic             o_meter_irq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  trim;
    logic [2:0]  div;
    logic        off;
    logic        hold;
    logic        bat;
    logic        tck;
    logic        por;
    logic        pend;
    logic [7:0]  gprev;
    logic [7:0]  ghold;
    logic [3:0]  xtal;
    logic [2:0]  mode;
    logic        fsel;
    logic        run;
    logic        fin;
    logic [5:0]  span;
    meter_e      st;
    logic [4:0]  sync;
    logic [24:0] left;
    logic [TALLY_W-1:0] tally;
    logic        ten;
    logic        den;
    logic [7:0]  srd;
    logic [7:0]  xrd;
  } top_s;
  top_s s_q, s_d;

  logic       div_tick;
  logic       fast_rise;
  logic       slow_rise;
  logic       slow_lvl;
  logic       bat_caught;
  logic       div_tick_q;

  clk_div u_div (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_sel   (s_q.div),
    .o_tick  (div_tick)
  );

  // interval clock mux
  always_comb
  begin
    case (s_q.mode)
      SRC_EXT: slow_lvl = i_ext_ref;
      SRC_OSC: slow_lvl = i_osc_clk;
      SRC_SYS: slow_lvl = div_tick;
      SRC_XTL: slow_lvl = i_crystal_clock;
      SRC_SLP: slow_lvl = i_sleep_tick;
      default: slow_lvl = 1'b0;
    endcase
  end

  edge_sync u_slow (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_lvl   (slow_lvl),
    .o_rise  (slow_rise)
  );

  edge_sync u_fast (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_lvl   (s_q.fsel ? i_divider_clk : i_tank_oscillator),
    .o_rise  (fast_rise)
  );

  // strap caught by clocked logic, not by the reset itself
  assign bat_caught = i_battery_insert;

  logic w_sys;
  logic w_ctl;
  logic w_spn;
  logic w_trm;
  logic w_xtl;

  always_comb
  begin
    s_d = s_q;
    w_sys = i_sfr_we && (i_sfr_addr == SFR_SYSTEM_CLOCK_POWER_CONTROL);
    w_ctl = i_sfr_we && (i_sfr_addr == SFR_METER_CTL);
    w_spn = i_sfr_we && (i_sfr_addr == SFR_METER_SPN);
    w_trm = i_xreg_we && (i_xreg_addr == XR_TRIM);
    w_xtl = i_xreg_we && (i_xreg_addr == XR_CRYSTAL);
    s_d.tck = 1'b0;
    s_d.por = 1'b0;
    s_d.gprev = i_gpio;
    if (bat_caught)
      s_d.bat = 1'b1;
    // ------------------------------------------------------------
    // clock generator and power control
    // ------------------------------------------------------------
    if (w_sys)
    begin
      s_d.div  = i_sfr_wdata[2:0];
      s_d.off  = i_sfr_wdata[SG_OFF];
      s_d.hold = i_sfr_wdata[SG_HLD];
      s_d.tck  = i_sfr_wdata[SG_TCK]; // write-only pulse
      if (i_sfr_wdata[SG_HLD] && !s_q.hold)
        s_d.ghold = i_gpio; // freeze ports
    end
    if (w_trm)
      s_d.trim = i_xreg_wdata;
    if (w_xtl)
      s_d.xtal = i_xreg_wdata[3:0];
    // press during hold is deferred, not acted on
    if (s_q.hold && !s_q.off && |(s_q.gprev & ~i_gpio))
      s_d.pend = 1'b1;
    // wake on any falling input edge once down
    if (s_q.off && (s_q.pend || |(s_q.gprev & ~i_gpio)))
    begin
      s_d.off  = 1'b0;
      s_d.hold = 1'b0;
      s_d.pend = 1'b0;
      s_d.por  = 1'b1;
    end
    // ------------------------------------------------------------
    // meter
    // ------------------------------------------------------------
    if (w_spn)
      s_d.span = i_sfr_wdata[5:0];
    case (s_q.st)
      M_IDLE: ;
      M_SYNC:
      begin
        s_d.sync = s_q.sync - 5'h01;
        if (s_q.sync == 5'h00)
          s_d.st = M_WAIT;
      end
      M_WAIT:
        if (slow_rise)
        begin
          s_d.st = M_CNT;
          s_d.left = span_cycles(s_q.span);
        end
      M_CNT:
      begin
        if (fast_rise)
          s_d.tally = s_q.tally + TALLY_W'(1); // live value
        if (slow_rise)
        begin
          s_d.left = s_q.left - 25'h0000001;
          if (s_q.left == 25'h0000001)
          begin
            s_d.st = M_FIN; // edge-to-edge span
            s_d.run = 1'b0;
            s_d.sync = SYNC_CYC;
          end
        end
      end
      M_FIN:
      begin
        s_d.sync = s_q.sync - 5'h01;
        if (s_q.sync == 5'h00)
        begin
          s_d.st = M_IDLE; // counters hold
          s_d.fin = 1'b1;
        end
      end
      default: s_d.st = M_IDLE;
    endcase
    if (w_ctl)
    begin
      s_d.mode = i_sfr_wdata[2:0];
      s_d.fsel = i_sfr_wdata[MC_FSL];
      s_d.fin  = i_sfr_wdata[MC_FIN]; // direct write
      if (i_sfr_wdata[MC_RUN] && i_sfr_wdata[2:0] != SRC_OFF)
      begin
        s_d.run   = 1'b1;
        s_d.fin   = 1'b0;
        s_d.tally = '0;
        s_d.sync  = SYNC_CYC;
        s_d.st    = M_SYNC;
      end
      if (i_sfr_wdata[2:0] == SRC_OFF)
      begin
        s_d.st  = M_IDLE;
        s_d.run = 1'b0;
      end
    end
    // completion wins over a same-cycle clear
    if (s_q.st == M_FIN && s_q.sync == 5'h00)
      s_d.fin = 1'b1;
    s_d.ten = (s_d.mode != SRC_OFF) && !s_d.fsel;
    s_d.den = (s_d.mode != SRC_OFF) && s_d.fsel;
    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    s_d.srd = 8'h00;
    if (i_sfr_re)
    begin
      case (i_sfr_addr)
        SFR_SYSTEM_CLOCK_POWER_CONTROL:
          s_d.srd = {s_q.off, 1'b0, s_q.bat, 1'b0, s_q.hold, s_q.div};
        SFR_METER_CTL:
          s_d.srd = {s_q.fin, s_q.run, s_q.fsel, 2'b00, s_q.mode};
        SFR_METER_SPN:
          s_d.srd = {2'b00, s_q.span};
        default: s_d.srd = 8'h00;
      endcase
    end
    s_d.xrd = 8'h00;
    if (i_xreg_re)
    begin
      case (i_xreg_addr)
        XR_TRIM:          s_d.xrd = s_q.trim;
        XR_CRYSTAL:       s_d.xrd = {4'h0, s_q.xtal};
        XR_TALLY:         s_d.xrd = s_q.tally[7:0];
        XR_TALLY + 16'h1: s_d.xrd = s_q.tally[15:8];
        XR_TALLY + 16'h2: s_d.xrd = {1'b0, s_q.tally[22:16]};
        XR_TALLY + 16'h3: s_d.xrd = 8'h00;
        default:          s_d.xrd = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s_q      <= '0;
      s_q.trim <= TRIM_RST;
      s_q.st   <= M_IDLE;
    end
    else
      s_q <= s_d;
  end

  // ------------------------------------------------------------
  // outputs, all straight from flops
  // ------------------------------------------------------------
  assign o_sfr_rdata           = s_q.srd;
  assign o_xreg_rdata          = s_q.xrd;
  // system clock keeps running whatever fast source the meter picks
  assign o_sysclk_tick         = div_tick_q;
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      div_tick_q <= 1'b0;
    else
      div_tick_q <= div_tick;
  end
  assign o_osc_trim_code       = s_q.trim;
  assign o_general_power_off   = s_q.off;
  assign o_power_on_reset      = s_q.por;
  assign o_port_hold           = s_q.hold;
  assign o_gpio_held           = s_q.ghold;
  assign o_button_pending      = s_q.pend;
  assign o_realtime_tick_clear = s_q.tck;
  assign o_crystal_bias_probe  = s_q.xtal[3:2];
  assign o_small_load_cap      = s_q.xtal[1];
  assign o_crystal_osc_on      = s_q.xtal[0];
  assign o_tank_enable         = s_q.ten;
  assign o_divider_enable      = s_q.den;
  assign o_meter_irq           = s_q.fin;
endmodule
`default_nettype wire

// File: tb/clkgen_checker.sv
`timescale 1ns/10ps
`default_nettype none
module clkgen_checker
  import clkgen_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_sfr_we,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic [7:0]  i_sfr_wdata,
  input wire logic        i_xreg_we,
  input wire logic [15:0] i_xreg_addr,
  input wire logic [7:0]  i_xreg_wdata,
  input wire logic        o_realtime_tick_clear,
  input wire logic [7:0]  o_osc_trim_code,
  input wire logic [1:0]  o_crystal_bias_probe,
  input wire logic        o_small_load_cap,
  input wire logic        o_crystal_osc_on,
  input wire logic        o_tank_enable,
  input wire logic        o_divider_enable,
  input wire logic        o_meter_irq,
  input wire logic        o_power_on_reset,
  input wire logic        o_port_hold,
  input wire logic [7:0]  o_gpio_held
);
  // ------------------------------------------------------------
  // write decode and properties
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic sg_w;
  logic mc_w;
  assign sg_w = i_sfr_we && i_sfr_addr == SFR_SYSTEM_CLOCK_POWER_CONTROL;
  assign mc_w = i_sfr_we && i_sfr_addr == SFR_METER_CTL;
  sequence tick_wr;
    sg_w && i_sfr_wdata[SG_TCK];
  endsequence
  sequence one_pulse;
    o_realtime_tick_clear ##1 !o_realtime_tick_clear;
  endsequence
  tick_clear_a: assert property (tick_wr |=> one_pulse)
    else $error("tick clear pulse wrong");
  tick_idle_a: assert property (sg_w && !i_sfr_wdata[SG_TCK] |=> !o_realtime_tick_clear)
    else $error("tick clear without request");
  trim_load_a: assert property (i_xreg_we && i_xreg_addr == XR_TRIM
    |=> o_osc_trim_code == $past(i_xreg_wdata)) else $error("trim not loaded");
  crystal_load_a: assert property (i_xreg_we && i_xreg_addr == XR_CRYSTAL |=>
    {o_crystal_bias_probe, o_small_load_cap, o_crystal_osc_on} == $past(i_xreg_wdata[3:0]))
    else $error("crystal control not loaded");
  irq_force_a: assert property (mc_w && i_sfr_wdata[7] && !i_sfr_wdata[6]
    |-> ##[1:2] o_meter_irq) else $error("irq not raised by write");
  irq_hold_a: assert property (o_meter_irq && !mc_w && !$past(mc_w) |=> o_meter_irq)
    else $error("irq dropped without write");
  fast_off_a: assert property (mc_w && i_sfr_wdata[2:0] == 3'h0
    |-> ##[1:2] (!o_tank_enable && !o_divider_enable)) else $error("fast source active");
  fast_sel_a: assert property (mc_w && |i_sfr_wdata[2:0] && !i_sfr_wdata[5]
    |-> ##[1:2] (o_tank_enable && !o_divider_enable)) else $error("tank not selected");
  por_pulse_a: assert property (o_power_on_reset |=> !o_power_on_reset)
    else $error("power on reset too long");
  hold_freeze_a: assert property (o_port_hold && $past(o_port_hold) |-> $stable(o_gpio_held))
    else $error("held port changed");
endmodule
bind clock_gen_freq_counter clkgen_checker chk (.i_clk, .i_reset, .i_sfr_we, .i_sfr_addr,
  .i_sfr_wdata, .i_xreg_we, .i_xreg_addr, .i_xreg_wdata, .o_realtime_tick_clear,
  .o_osc_trim_code, .o_crystal_bias_probe, .o_small_load_cap, .o_crystal_osc_on,
  .o_tank_enable, .o_divider_enable, .o_meter_irq, .o_power_on_reset, .o_port_hold,
  .o_gpio_held);
`default_nettype wire

// File: tb/clock_gen_freq_counter_bench.sv
`timescale 1ns/10ps
`default_nettype none
module clock_gen_freq_counter_bench;
  // ------------------------------------------------------------
  // stimulus, slow and fast sources on fixed phases
  // ------------------------------------------------------------
  logic i_clk = 0, i_reset = 1, i_battery_insert = 0;
  logic i_sfr_we = 0, i_sfr_re = 0, i_xreg_we = 0, i_xreg_re = 0;
  logic [7:0] i_sfr_addr = 0, i_sfr_wdata = 0, i_xreg_wdata = 0, i_gpio = 8'hff;
  logic [15:0] i_xreg_addr = 0;
  logic i_ext_ref = 0, i_osc_clk = 0, i_crystal_clock = 0, i_sleep_tick = 0;
  logic i_tank_oscillator = 0, i_divider_clk = 0;
  logic [7:0] o_sfr_rdata, o_xreg_rdata, o_osc_trim_code, o_gpio_held;
  logic [1:0] o_crystal_bias_probe;
  logic o_sysclk_tick, o_general_power_off, o_power_on_reset, o_port_hold, o_button_pending;
  logic o_realtime_tick_clear, o_small_load_cap, o_crystal_osc_on, o_tank_enable;
  logic o_divider_enable, o_meter_irq;
  int cyc = 0, por_n = 0, fail_count = 0, cmp_count = 0;
  clock_gen_freq_counter dut (.i_clk, .i_reset, .i_sfr_we, .i_sfr_re, .i_sfr_addr,
    .i_sfr_wdata, .o_sfr_rdata, .i_xreg_we, .i_xreg_re, .i_xreg_addr, .i_xreg_wdata,
    .o_xreg_rdata, .i_battery_insert, .i_gpio, .i_ext_ref, .i_osc_clk, .i_crystal_clock,
    .i_sleep_tick, .i_tank_oscillator, .i_divider_clk, .o_sysclk_tick, .o_osc_trim_code,
    .o_general_power_off, .o_power_on_reset, .o_port_hold, .o_gpio_held, .o_button_pending,
    .o_realtime_tick_clear, .o_crystal_bias_probe, .o_small_load_cap, .o_crystal_osc_on,
    .o_tank_enable, .o_divider_enable, .o_meter_irq);
  initial
  begin
    forever #2 i_clk = ~i_clk;
  end
  // fast rises sit off the slow rises so every tally is exact
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    i_ext_ref <= #1 (cyc % 64) < 32;
    i_osc_clk <= #1 (cyc % 32) < 16;
    i_crystal_clock <= #1 (cyc % 128) < 64;
    i_sleep_tick <= #1 (cyc % 96) < 48;
    i_tank_oscillator <= #1 ((cyc + 6) % 8) < 4;
    i_divider_clk <= #1 ((cyc + 10) % 16) < 8;
    if (o_power_on_reset === 1'b1)
      por_n <= por_n + 1;
    if (cyc == 30000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic x, input logic w, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    i_sfr_addr = a[7:0];
    i_xreg_addr = a;
    i_sfr_wdata = d;
    i_xreg_wdata = d;
    {i_sfr_we, i_xreg_we, i_sfr_re, i_xreg_re} = {w & ~x, w & x, ~w & ~x, ~w & x};
    @(posedge i_clk) #1;
    r = x ? o_xreg_rdata : o_sfr_rdata;
    {i_sfr_we, i_xreg_we, i_sfr_re, i_xreg_re} = 4'h0;
    @(posedge i_clk) #1;
  endtask
  task automatic wr(input logic x, input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    acc(x, 1'b1, a, d, r);
  endtask
  task automatic rd(input logic x, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] r;
    acc(x, 1'b0, a, 8'h00, r);
    check({24'h0, r}, {24'h0, e});
  endtask
  task automatic tally(output logic [31:0] t);
    logic [7:0] r;
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, 1'b0, 16'h4008 + 16'(i), 8'h00, r);
      t[8*i+:8] = r;
    end
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    int n;
    int nc;
    logic [7:0] ctl;
    logic [31:0] t1, t2;
    static int md[6] = '{1, 2, 4, 6, 1, 3};
    static int fs[6] = '{0, 1, 0, 1, 0, 1};
    static int cd[6] = '{0, 1, 44, 2, 3, 0};
    static int pp[6] = '{64, 32, 128, 96, 64, 0};
    repeat (3) @(posedge i_clk);
    #1 i_reset = 0;
    @(posedge i_clk) #1;
    rd(1, 16'h4002, 8'hff);
    check(o_osc_trim_code, 8'hff);
    rd(1, 16'h4016, 8'h00);
    rd(0, 16'h00be, 8'h00);
    rd(0, 16'h0000, 8'h00);
    rd(1, 16'h4000, 8'h00);
    wr(1, 16'h4002, 8'h00);
    rd(1, 16'h4002, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(1, 16'h4016, 8'hf0 | 8'(i * 5));
      rd(1, 16'h4016, 8'(i * 5));
      check({o_crystal_bias_probe, o_small_load_cap, o_crystal_osc_on}, i * 5);
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(0, 16'h00be, 8'(i));
      rd(0, 16'h00be, 8'(i));
      repeat (2)
      begin
        n = 0;
        while (o_sysclk_tick !== 1'b1 && n < 400) @(posedge i_clk) #1 n++;
        n = 0;
        do @(posedge i_clk) #1 n++; while (o_sysclk_tick !== 1'b1 && n < 400);
      end
      check(n, 1 << i);
    end
    wr(0, 16'h00be, 8'h17);
    wr(0, 16'h00be, 8'h07);
    rd(0, 16'h00be, 8'h07);
    i_gpio = 8'ha5;
    @(posedge i_clk) #1;
    wr(0, 16'h00be, 8'h0f);
    check({o_port_hold, o_general_power_off, o_gpio_held}, 10'h2a5);
    i_gpio = 8'h25;
    repeat (4) @(posedge i_clk) #1;
    check({o_button_pending, o_gpio_held}, 9'h1a5);
    wr(0, 16'h00be, 8'h8f);
    repeat (50) @(posedge i_clk) #1;
    check({o_general_power_off, o_port_hold, 8'(por_n)}, 10'h001);
    i_gpio = 8'hff;
    wr(0, 16'h00be, 8'h8f);
    repeat (10) @(posedge i_clk) #1;
    check({o_general_power_off, 8'(por_n)}, 9'h101);
    i_gpio = 8'hfe;
    repeat (50) @(posedge i_clk) #1;
    check({o_general_power_off, 8'(por_n)}, 9'h002);
    i_battery_insert = 1;
    @(posedge i_clk) #1 i_battery_insert = 0;
    wr(0, 16'h00be, 8'h07);
    rd(0, 16'h00be, 8'h27);
    wr(0, 16'h009d, 8'h03);
    wr(0, 16'h009b, 8'h41);
    repeat (150) @(posedge i_clk) #1;
    tally(t1);
    repeat (40) @(posedge i_clk) #1;
    tally(t2);
    check(t1 != t2, 1);
    wr(0, 16'h009b, 8'h41);
    rd(1, 16'h4008, 8'h00);
    repeat (150) @(posedge i_clk) #1;
    wr(0, 16'h009b, 8'h00);
    tally(t1);
    repeat (100) @(posedge i_clk) #1;
    tally(t2);
    check(t2, t1);
    rd(0, 16'h009b, 8'h00);
    check({o_meter_irq, o_tank_enable, o_divider_enable}, 3'h0);
    for (int k = 0; k < 6; k++)
    begin
      ctl = 8'h40 | 8'(fs[k] << 5) | 8'(md[k]);
      nc = (cd[k] > 43) ? 1 : (2 + cd[k] % 2) << (cd[k] / 2);
      wr(0, 16'h009d, 8'(cd[k]));
      wr(0, 16'h009b, ctl);
      rd(0, 16'h009b, ctl);
      check({o_tank_enable, o_divider_enable}, fs[k] ? 1 : 2);
      n = 0;
      while (o_meter_irq !== 1'b1 && n < 3000) @(posedge i_clk) #1 n++;
      rd(0, 16'h009b, ctl ^ 8'hc0);
      tally(t1);
      if (pp[k] != 0)
        check(t1, nc * pp[k] / (fs[k] ? 16 : 8));
    end
    repeat (200) @(posedge i_clk) #1;
    tally(t2);
    check(t2, t1);
    rd(1, 16'h400b, 8'h00);
    wr(0, 16'h009b, 8'h01);
    check(o_meter_irq, 0);
    wr(0, 16'h009b, 8'h81);
    check(o_meter_irq, 1);
    wr(0, 16'h009b, 8'h40);
    rd(0, 16'h009b, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
